// ==== design/lps_pkg.sv ====
package lps_pkg;

  // Register offsets on the two-wire bus
  localparam logic [4:0] LPS_OFF_ENABLE = 5'h00;
  localparam logic [4:0] LPS_OFF_LTIME  = 5'h01;
  localparam logic [4:0] LPS_OFF_WAIT_TIME_REG  = 5'h03;
  localparam logic [4:0] LPS_OFF_CONFIG = 5'h0D;
  localparam logic [4:0] LPS_OFF_GAIN   = 5'h0F;
  localparam logic [4:0] LPS_OFF_STATUS = 5'h13;
  localparam logic [4:0] LPS_OFF_C0L    = 5'h14;
  localparam logic [4:0] LPS_OFF_C0H    = 5'h15;
  localparam logic [4:0] LPS_OFF_C1L    = 5'h16;
  localparam logic [4:0] LPS_OFF_C1H    = 5'h17;

  // Reset values
  localparam logic [7:0] LPS_RST_ENABLE = 8'h00;
  localparam logic [7:0] LPS_RST_TIME   = 8'hFF;
  localparam logic [7:0] LPS_RST_BYTE   = 8'h00;

  // Field positions
  localparam int LPS_CFG_GAIN_LOW = 2;
  localparam int LPS_ST_LVALID    = 0;
  localparam int LPS_ST_LIRQ      = 4;
  localparam int LPS_ST_PIRQ      = 5;

  // Timing: one 2.73 ms step at the 100 MHz system clock
  localparam int LPS_STEP_TIME_NS = 2730000;
  localparam int LPS_CLK_NS       = 10;
  localparam int LPS_STEP_CYCLES  = (LPS_STEP_TIME_NS + LPS_CLK_NS - 1) / LPS_CLK_NS;
  localparam logic [8:0] LPS_FULL_COUNT = 9'h100;
  localparam logic [8:0] LPS_PROX_STEPS = 9'h001;

  // Bus framing
  localparam logic [3:0] LPS_BITS_BYTE = 4'h8;
  localparam logic [6:0] LPS_DEF_ADDR  = 7'h2A;

  // Light gain times six, index {gain_low, gain_sel}
  localparam logic [9:0] LPS_GAIN_X6 [0:7] = '{10'h006, 10'h030, 10'h060, 10'h2D0,
                                               10'h001, 10'h008, 10'h010, 10'h078};

  // Operating enable register layout
  typedef struct packed {
    logic rsvd;
    logic sleep_after_irq;
    logic prox_irq_enable;
    logic light_irq_enable;
    logic wait_enable_bit;
    logic prox_enable_bit;
    logic light_enable_bit;
    logic power_on_bit;
  } lps_enable_t;

  // Pair of light channel counts
  typedef struct packed {
    logic [15:0] chan1_count;
    logic [15:0] chan0_count;
  } lps_counts_t;

  typedef enum logic [2:0] {LPS_SLEEP, LPS_IDLE, LPS_PROX, LPS_WAIT, LPS_LIGHT} lps_seq_t;
  typedef enum logic [2:0] {LPS_I_IDLE, LPS_I_ADDR, LPS_I_AACK, LPS_I_WR, LPS_I_WACK,
                            LPS_I_RD, LPS_I_RACK} lps_bus_t;

endpackage

// ==== design/lps_step_timer.sv ====
`timescale 1ns/1ps
`default_nettype none

module lps_step_timer
  import lps_pkg::*;
#(
  parameter int STEP_CYC = LPS_STEP_CYCLES
) (
  // Clock and reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst_b,
  // Request
  input  wire logic       i_start,
  input  wire logic [8:0] i_steps,
  // Answer
  output logic            o_done
);

  logic [31:0] cyc_q;
  logic [8:0]  steps_q;
  logic        busy_q;

  // Counts whole steps, each STEP_CYC clocks long
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cyc_q   <= '0;
      steps_q <= '0;
      busy_q  <= 1'b0;
      o_done  <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (i_start) begin
        cyc_q   <= '0;
        steps_q <= i_steps;
        busy_q  <= 1'b1;
      end else if (busy_q) begin
        if (cyc_q == 32'(STEP_CYC - 1)) begin
          cyc_q <= '0;
          if (steps_q <= 9'h001) begin
            busy_q <= 1'b0;
            o_done <= 1'b1;
          end else begin
            steps_q <= steps_q - 9'h001;
          end
        end else begin
          cyc_q <= cyc_q + 32'h1;
        end
      end
    end
  end

endmodule

`default_nettype wire

// ==== design/lps_sequencer.sv ====
// How it works
// - After reset all but the light and wait time registers (loaded 0xFF) are cleared and the sequencer sleeps, measuring nothing.
// - A bus start condition while asleep moves it to Idle to check power_on_bit.
// - In Idle with power_on_bit clear, it returns to Sleep.
// - With power_on_bit set, Idle holds until prox or light enable is set.
// - Enabled cycles run proximity, then wait, then light, always that order.
// - Back in Idle, a new cycle starts while power and a prox or light enable stay set.
// - A threshold event with sleep_after_irq set sends it to Sleep until the next command.
// - Both channels integrate together; at the end both counts are stored.
// - Count reads are double-buffered so a byte pair is never torn.
// - After storing light counts it returns to Idle.
// - Light integration lasts 256 minus light_time_reg steps of 2.73 ms.
// - light_gain_sel selects gain 1, 8, 16 or 120.
// - light_gain_low lowers those gains to 1/6, 8/6, 16/6 and 20.
// - Channel 0 count: low byte at 0x14, high byte at 0x15.
// - Channel 1 count: low byte at 0x16, high byte at 0x17.
// - Interrupt status always updates; the pin follows only enabled sources.
`timescale 1ns/1ps
`default_nettype none

module lps_sequencer
  import lps_pkg::*;
#(
  parameter int         STEP_CYC = LPS_STEP_CYCLES,
  parameter logic [6:0] DEV_ADDR = LPS_DEF_ADDR     // arbitrary bus address
) (
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_b,
  // Two-wire register bus
  input  wire logic        i_scl,
  input  wire logic        i_sda,
  output logic             o_sda_oe_b,
  // Light converters and measurement controls
  input  wire logic [15:0] i_adc_ch0,
  input  wire logic [15:0] i_adc_ch1,
  output logic             o_prox_active,
  output logic             o_light_integ,
  output logic             o_asleep,
  output logic [9:0]       o_gain_x6,
  // Threshold events and interrupt pin
  input  wire logic        i_prox_irq,
  input  wire logic        i_light_irq,
  output logic             o_int_b
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release and bus pin synchronisers

  logic [1:0]  rst_q;
  logic        rst_b;
  logic [1:0]  scl_s, sda_s;
  logic        scl_p, sda_p;
  logic        scl_rise, scl_fall, bus_start, bus_stop;

  // Asynchronous assert, two-flop release
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_q <= 2'b00;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_b = rst_q[1];

  // Two flops per pin, then a history flop for edges
  always_ff @(posedge i_clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      scl_s <= 2'b11;
      sda_s <= 2'b11;
      scl_p <= 1'b1;
      sda_p <= 1'b1;
    end else begin
      scl_s <= {scl_s[0], i_scl};
      sda_s <= {sda_s[0], i_sda};
      scl_p <= scl_s[1];
      sda_p <= sda_s[1];
    end
  end

  // Bus events
  assign scl_rise  = scl_s[1] & ~scl_p;
  assign scl_fall  = ~scl_s[1] & scl_p;
  assign bus_start = scl_s[1] & scl_p & sda_p & ~sda_s[1];
  assign bus_stop  = scl_s[1] & scl_p & ~sda_p & sda_s[1];

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave framing

  lps_bus_t   ist_q;
  logic [3:0] bitc_q;
  logic [7:0] rx_q, tx_q, rd_byte;
  logic       rw_q;
  logic       wr_ev, rd_load, rd_adv;

  assign wr_ev   = scl_fall & (ist_q == LPS_I_WR) & (bitc_q == LPS_BITS_BYTE);
  assign rd_load = scl_fall & (((ist_q == LPS_I_AACK) & rw_q) | (ist_q == LPS_I_RACK));
  assign rd_adv  = scl_rise & (ist_q == LPS_I_RACK) & ~sda_s[1];

  // Byte shifter, acknowledge and read data drive
  always_ff @(posedge i_clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ist_q      <= LPS_I_IDLE;
      bitc_q     <= '0;
      rx_q       <= LPS_RST_BYTE;
      tx_q       <= LPS_RST_BYTE;
      rw_q       <= 1'b0;
      o_sda_oe_b <= 1'b1;
    end else if (bus_start) begin
      ist_q      <= LPS_I_ADDR;
      bitc_q     <= '0;
      o_sda_oe_b <= 1'b1;
    end else if (bus_stop) begin
      ist_q      <= LPS_I_IDLE;
      o_sda_oe_b <= 1'b1;
    end else if (scl_rise) begin
      case (ist_q)
        LPS_I_ADDR, LPS_I_WR: begin
          rx_q   <= {rx_q[6:0], sda_s[1]};
          bitc_q <= bitc_q + 4'h1;
        end
        LPS_I_RD: bitc_q <= bitc_q + 4'h1;
        LPS_I_RACK: if (sda_s[1]) ist_q <= LPS_I_IDLE; // Master NACK ends read
        default: ;
      endcase
    end else if (scl_fall) begin
      case (ist_q)
        LPS_I_ADDR: begin
          if (bitc_q == LPS_BITS_BYTE) begin
            if (rx_q[7:1] == DEV_ADDR) begin
              o_sda_oe_b <= 1'b0;
              rw_q       <= rx_q[0];
              ist_q      <= LPS_I_AACK;
            end else begin
              ist_q <= LPS_I_IDLE;
            end
          end
        end
        LPS_I_AACK, LPS_I_RACK: begin
          bitc_q <= '0;
          if (rd_load) begin
            o_sda_oe_b <= rd_byte[7];
            tx_q       <= {rd_byte[6:0], 1'b0};
            ist_q      <= LPS_I_RD;
          end else begin
            o_sda_oe_b <= 1'b1;
            ist_q      <= LPS_I_WR;
          end
        end
        LPS_I_WR: begin
          if (bitc_q == LPS_BITS_BYTE) begin
            o_sda_oe_b <= 1'b0;
            ist_q      <= LPS_I_WACK;
          end
        end
        LPS_I_WACK: begin
          o_sda_oe_b <= 1'b1;
          bitc_q     <= '0;
          ist_q      <= LPS_I_WR;
        end
        LPS_I_RD: begin
          if (bitc_q == LPS_BITS_BYTE) begin
            o_sda_oe_b <= 1'b1;
            ist_q      <= LPS_I_RACK;
          end else begin
            o_sda_oe_b <= tx_q[7];
            tx_q       <= {tx_q[6:0], 1'b0};
          end
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file

  lps_enable_t en_q;
  lps_counts_t cnt_q, hold_q;
  logic [7:0]  ltime_q, wait_time_reg_q, gain_q, cfg_q, status;
  logic [4:0]  ptr_q;
  logic        first_q, lvalid_q, pirq_q, lirq_q;
  logic        light_done;

  // Pointer: first written byte selects, each later written byte or acknowledged read byte advances
  always_ff @(posedge i_clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ptr_q   <= '0;
      first_q <= 1'b0;
    end else if (bus_start) begin
      first_q <= 1'b1;
    end else if (wr_ev) begin
      first_q <= 1'b0;
      ptr_q   <= first_q ? rx_q[4:0] : ptr_q + 5'h01;
    end else if (rd_adv) begin
      ptr_q <= ptr_q + 5'h01;
    end
  end

  // Writable control registers
  always_ff @(posedge i_clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      en_q    <= LPS_RST_ENABLE;
      ltime_q <= LPS_RST_TIME;
      wait_time_reg_q <= LPS_RST_TIME;
      gain_q  <= LPS_RST_BYTE;
      cfg_q   <= LPS_RST_BYTE;
    end else if (wr_ev && !first_q) begin
      case (ptr_q)
        LPS_OFF_ENABLE: en_q    <= rx_q;
        LPS_OFF_LTIME:  ltime_q <= rx_q;
        LPS_OFF_WAIT_TIME_REG:  wait_time_reg_q <= rx_q;
        LPS_OFF_GAIN:   gain_q  <= rx_q;
        LPS_OFF_CONFIG: cfg_q   <= rx_q;
        default: ;
      endcase
    end
  end

  // Interrupt status: events always latch, write-one clears, set wins
  always_ff @(posedge i_clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pirq_q <= 1'b0;
      lirq_q <= 1'b0;
      o_int_b <= 1'b1;
    end else begin
      pirq_q <= i_prox_irq | (pirq_q & ~(wr_ev & ~first_q & (ptr_q == LPS_OFF_STATUS)
                & rx_q[LPS_ST_PIRQ]));
      lirq_q <= i_light_irq | (lirq_q & ~(wr_ev & ~first_q & (ptr_q == LPS_OFF_STATUS)
                & rx_q[LPS_ST_LIRQ]));
      o_int_b <= ~((pirq_q & en_q.prox_irq_enable) | (lirq_q & en_q.light_irq_enable));
    end
  end

  // Both channel results land together at the end of integration
  always_ff @(posedge i_clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q    <= '0;
      lvalid_q <= 1'b0;
    end else if (light_done) begin
      cnt_q    <= '{chan1_count: i_adc_ch1, chan0_count: i_adc_ch0};
      lvalid_q <= 1'b1;
    end
  end

  // Reading a low byte freezes the pair for the high byte read
  always_ff @(posedge i_clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      hold_q <= '0;
    end else if (rd_load && (ptr_q == LPS_OFF_C0L || ptr_q == LPS_OFF_C1L)) begin
      hold_q <= cnt_q;
    end
  end

  always_comb begin
    status = '0;
    status[LPS_ST_LVALID] = lvalid_q;
    status[LPS_ST_LIRQ]   = lirq_q;
    status[LPS_ST_PIRQ]   = pirq_q;
  end

  // Read data mux; unmapped offsets read zero
  always_comb begin
    case (ptr_q)
      LPS_OFF_ENABLE: rd_byte = en_q;
      LPS_OFF_LTIME:  rd_byte = ltime_q;
      LPS_OFF_WAIT_TIME_REG:  rd_byte = wait_time_reg_q;
      LPS_OFF_GAIN:   rd_byte = gain_q;
      LPS_OFF_CONFIG: rd_byte = cfg_q;
      LPS_OFF_STATUS: rd_byte = status;
      LPS_OFF_C0L:    rd_byte = cnt_q.chan0_count[7:0];
      LPS_OFF_C0H:    rd_byte = hold_q.chan0_count[15:8];
      LPS_OFF_C1L:    rd_byte = cnt_q.chan1_count[7:0];
      LPS_OFF_C1H:    rd_byte = hold_q.chan1_count[15:8];
      default:        rd_byte = LPS_RST_BYTE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Measurement sequencer

  lps_seq_t   seq_q, seq_d;
  logic       tmr_start_q, tmr_done, tmr_fin;
  logic [8:0] tmr_steps_q;

  // First enabled state at or after a stage of the cycle
  function automatic lps_seq_t stage_from(input logic [1:0] st, input lps_enable_t en);
    if (st == 2'd0 && en.prox_enable_bit) return LPS_PROX;
    if (st <= 2'd1 && en.wait_enable_bit) return LPS_WAIT;
    if (st <= 2'd2 && en.light_enable_bit) return LPS_LIGHT;
    return LPS_IDLE;
  endfunction

  // Steps a state lasts
  function automatic logic [8:0] steps_for(input lps_seq_t s, input logic [7:0] lt,
                                           input logic [7:0] wt);
    case (s)
      LPS_WAIT:  return LPS_FULL_COUNT - {1'b0, wt};
      LPS_LIGHT: return LPS_FULL_COUNT - {1'b0, lt};
      default:   return LPS_PROX_STEPS;
    endcase
  endfunction

  // Ignore a stale end pulse from a timer run cut short by sleep
  assign tmr_fin    = tmr_done & ~tmr_start_q;
  assign light_done = (seq_q == LPS_LIGHT) & tmr_fin;

  // Next state
  always_comb begin
    seq_d = seq_q;
    case (seq_q)
      LPS_SLEEP: if (bus_start) seq_d = LPS_IDLE;
      LPS_IDLE: begin
        if (!en_q.power_on_bit) seq_d = LPS_SLEEP;
        else if (en_q.prox_enable_bit || en_q.light_enable_bit) seq_d = stage_from(2'd0, en_q);
      end
      LPS_PROX:  if (tmr_fin) seq_d = stage_from(2'd1, en_q);
      LPS_WAIT:  if (tmr_fin) seq_d = stage_from(2'd2, en_q);
      LPS_LIGHT: if (tmr_fin) seq_d = LPS_IDLE;
      default:   seq_d = LPS_SLEEP;
    endcase
    if (seq_q != LPS_SLEEP && (i_prox_irq || i_light_irq) && en_q.sleep_after_irq) begin
      seq_d = LPS_SLEEP;
    end
  end

  // State register and timer launch on each entry to Prox, Wait or Light
  always_ff @(posedge i_clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      seq_q       <= LPS_SLEEP;
      tmr_start_q <= 1'b0;
      tmr_steps_q <= LPS_PROX_STEPS;
    end else begin
      seq_q       <= seq_d;
      tmr_start_q <= (seq_d != seq_q) && (seq_d == LPS_PROX || seq_d == LPS_WAIT
                     || seq_d == LPS_LIGHT);
      tmr_steps_q <= steps_for(seq_d, ltime_q, wait_time_reg_q);
    end
  end

  // Registered measurement controls and gain
  always_ff @(posedge i_clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      o_prox_active <= 1'b0;
      o_light_integ <= 1'b0;
      o_asleep      <= 1'b1;
      o_gain_x6     <= LPS_GAIN_X6[0];
    end else begin
      o_prox_active <= (seq_d == LPS_PROX);
      o_light_integ <= (seq_d == LPS_LIGHT);
      o_asleep      <= (seq_d == LPS_SLEEP);
      o_gain_x6     <= LPS_GAIN_X6[{cfg_q[LPS_CFG_GAIN_LOW], gain_q[1:0]}];
    end
  end

  lps_step_timer #(
    .STEP_CYC (STEP_CYC)
  ) u_timer (
    .i_clk_sys (i_clk_sys),
    .i_rst_b   (rst_b),
    .i_start   (tmr_start_q),
    .i_steps   (tmr_steps_q),
    .o_done    (tmr_done)
  );

endmodule

`default_nettype wire

// ==== verif/lps_sequencer_props.sv ====
`timescale 1ns/1ps
`default_nettype none

module lps_sequencer_props
  import lps_pkg::*;
#(
  parameter int STEP_CYC = 20
) (
  // Clock and reset
  input wire logic        i_clk_sys,
  input wire logic        i_rst_b,
  // Bus pins
  input wire logic        i_scl,
  input wire logic        i_sda,
  input wire logic        o_sda_oe_b,
  // Measurement side
  input wire logic [15:0] i_adc_ch0,
  input wire logic [15:0] i_adc_ch1,
  input wire logic        o_prox_active,
  input wire logic        o_light_integ,
  input wire logic        o_asleep,
  input wire logic [9:0]  o_gain_x6,
  // Events and interrupt
  input wire logic        i_prox_irq,
  input wire logic        i_light_irq,
  input wire logic        o_int_b
);
  logic [15:0] prox_len_q;
  logic [15:0] light_len_q;

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_b);

  ////////////////////////////////////////////////////////////////////////////
  // Run length of the proximity window
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      prox_len_q <= '0;
    end else begin
      prox_len_q <= o_prox_active ? prox_len_q + 16'h1 : 16'h0;
    end
  end

  // Run length of light integration
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      light_len_q <= '0;
    end else begin
      light_len_q <= o_light_integ ? light_len_q + 16'h1 : 16'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_reset_asleep: assert property ($rose(i_rst_b) |-> o_asleep ##1 o_asleep)
    else $error("not asleep after reset");
  a_sleep_quiet: assert property (o_asleep |-> !o_prox_active && !o_light_integ)
    else $error("measuring while asleep");
  a_stage_exclusive: assert property (!(o_prox_active && o_light_integ))
    else $error("two stages at once");
  a_prox_one_step: assert property ($fell(o_prox_active) && !o_asleep |->
    prox_len_q >= STEP_CYC && prox_len_q <= STEP_CYC + 3)
    else $error("proximity window length off");
  a_light_min_len: assert property ($fell(o_light_integ) && !o_asleep |->
    light_len_q >= STEP_CYC)
    else $error("light integration too short");
  a_wake_on_start: assert property (o_asleep && i_scl && $fell(i_sda) |-> ##[1:8] !o_asleep)
    else $error("start did not wake");
  a_stay_asleep: assert property (($stable(i_sda) && o_asleep)[*6] |=> o_asleep)
    else $error("left sleep without a command");
  a_int_holds: assert property ($fell(o_int_b) |=> (!o_int_b)[*4])
    else $error("interrupt not held");
  a_gain_legal: assert property (o_gain_x6 inside {10'h006, 10'h030, 10'h060, 10'h2D0,
    10'h001, 10'h008, 10'h010, 10'h078})
    else $error("illegal gain");
endmodule

bind lps_sequencer lps_sequencer_props #(.STEP_CYC(STEP_CYC)) lps_sequencer_props_inst (
  .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_scl(i_scl), .i_sda(i_sda),
  .o_sda_oe_b(o_sda_oe_b), .i_adc_ch0(i_adc_ch0), .i_adc_ch1(i_adc_ch1),
  .o_prox_active(o_prox_active), .o_light_integ(o_light_integ), .o_asleep(o_asleep),
  .o_gain_x6(o_gain_x6), .i_prox_irq(i_prox_irq), .i_light_irq(i_light_irq),
  .o_int_b(o_int_b)
);

`default_nettype wire

// ==== verif/lps_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module lps_host_model (
  // Bus lines, 1 releases to the pull-up
  output logic      o_scl,
  output logic      o_sda,
  input  wire logic i_sda
);
  // Quarter of the 125 ns bus period
  localparam realtime Q = 31.25;

  // Idle bus: clock stands high
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end

  // Start or repeated start
  task automatic start();
    o_sda = 1'b1;
    #Q o_scl = 1'b1;
    #Q o_sda = 1'b0;
    #Q o_scl = 1'b0;
    #Q;
  endtask

  // One bit out, line sampled mid-high
  task automatic bit_io(input logic b, output logic r);
    o_sda = b;
    #Q o_scl = 1'b1;
    #Q r = i_sda;
    #Q o_scl = 1'b0;
    #Q;
  endtask

  // Eight data bits then the acknowledge slot
  task automatic byte_io(input logic [7:0] b, input logic ack_in,
                         output logic [7:0] r, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], r[i]);
    end
    bit_io(ack_in, ack);
  endtask

  // Stop: data rises while clock high
  task automatic stop();
    o_sda = 1'b0;
    #Q o_scl = 1'b1;
    #Q o_sda = 1'b1;
    #Q;
  endtask
endmodule

`default_nettype wire

// ==== verif/lps_sequencer_tb.sv ====
`timescale 1ns/1ps
`default_nettype none

module lps_sequencer_tb;
  import lps_pkg::*;
  localparam int S = 20;
  logic        clk, rst_b, scl, host_sda, sda_w, oe_b, prox_irq, light_irq;
  logic        prox_act, light_int, asleep, int_b;
  logic [15:0] adc0, adc1, c0, c1, seen_v;
  logic [9:0]  gain;
  logic [15:0] exp_q[$];
  logic [9:0]  gtab[8] = '{10'h006, 10'h030, 10'h060, 10'h2D0,
                           10'h001, 10'h008, 10'h010, 10'h078};
  integer      seed = 32'h1C374EFA;
  int          mismatches, total_checks, n, gap;
  event        seen_ev;

  assign sda_w = host_sda & oe_b;

  lps_sequencer #(.STEP_CYC(S)) lps_sequencer_inst (
    .i_clk_sys(clk), .i_rst_b(rst_b), .i_scl(scl), .i_sda(sda_w), .o_sda_oe_b(oe_b),
    .i_adc_ch0(adc0), .i_adc_ch1(adc1), .o_prox_active(prox_act),
    .o_light_integ(light_int), .o_asleep(asleep), .o_gain_x6(gain),
    .i_prox_irq(prox_irq), .i_light_irq(light_irq), .o_int_b(int_b)
  );
  lps_host_model lps_host_model_inst (.o_scl(scl), .o_sda(host_sda), .i_sda(sda_w));

  ////////////////////////////////////////////////////////////////////////////
  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Note expectation, present the seen value
  task automatic chk(input logic [15:0] e, input logic [15:0] s);
    exp_q.push_back(e);
    seen_v = s;
    ->seen_ev;
    wait (exp_q.size() == 0);
  endtask

  task automatic compare(input logic [15:0] s, input logic [15:0] e);
    total_checks++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  // Watcher takes the oldest note
  initial forever begin
    @(seen_ev);
    compare(seen_v, exp_q.pop_front());
  end

  // Register write of n bytes from ptr a
  task automatic wr(input logic [4:0] a, input int cnt, input logic [31:0] d);
    logic [7:0] r;
    logic       k;
    @(negedge clk);
    #2;
    lps_host_model_inst.start();
    lps_host_model_inst.byte_io({LPS_DEF_ADDR, 1'b0}, 1'b1, r, k);
    chk(16'h0, {15'h0, k});
    lps_host_model_inst.byte_io({3'h0, a}, 1'b1, r, k);
    for (int i = 0; i < cnt; i++) begin
      lps_host_model_inst.byte_io(d[8*i+:8], 1'b1, r, k);
      chk(16'h0, {15'h0, k});
    end
    lps_host_model_inst.stop();
    repeat (4) @(negedge clk);
  endtask

  // Register read of n bytes under a mask
  task automatic rd(input logic [4:0] a, input int cnt, input logic [31:0] e,
                    input logic [7:0] m);
    logic [7:0] r;
    logic       k;
    @(negedge clk);
    #2;
    lps_host_model_inst.start();
    lps_host_model_inst.byte_io({LPS_DEF_ADDR, 1'b0}, 1'b1, r, k);
    lps_host_model_inst.byte_io({3'h0, a}, 1'b1, r, k);
    lps_host_model_inst.start();
    lps_host_model_inst.byte_io({LPS_DEF_ADDR, 1'b1}, 1'b1, r, k);
    for (int i = 0; i < cnt; i++) begin
      lps_host_model_inst.byte_io(8'hFF, i == cnt - 1, r, k);
      chk({8'h0, e[8*i+:8] & m}, {8'h0, r & m});
    end
    lps_host_model_inst.stop();
  endtask

  function automatic logic pick(input int w);
    return (w == 0) ? prox_act : light_int;
  endfunction

  // Bounded wait for a stage output level
  task automatic wait_for(input int w, input logic lvl, output int cnt);
    cnt = 0;
    while (pick(w) !== lvl && cnt < 9000) begin
      @(negedge clk);
      cnt++;
    end
    if (cnt >= 9000) mismatches++;
  endtask

  // One-cycle event pulse
  task automatic pulse(input int w);
    @(negedge clk);
    if (w == 0) prox_irq = 1'b1;
    else light_irq = 1'b1;
    @(negedge clk);
    prox_irq = 1'b0;
    light_irq = 1'b0;
    repeat (3) @(negedge clk);
  endtask

  task automatic report_and_stop();
    if (mismatches == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    #900000;
    mismatches++;
    report_and_stop();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst_b = 1'b0;
    prox_irq = 1'b0;
    light_irq = 1'b0;
    c0 = $random(seed);
    c1 = $random(seed);
    adc0 = c0;
    adc1 = c1;
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    repeat (10) @(negedge clk);
    chk(16'h1, {15'h0, asleep});
    chk(16'h1, {15'h0, int_b});
    chk(16'h6, {6'h0, gain});
    wr(LPS_OFF_ENABLE, 1, 32'h0);
    chk(16'h1, {15'h0, asleep});
    rd(5'h02, 1, 32'h0, 8'hFF);
    for (int i = 0; i < 8; i++) begin
      wr(LPS_OFF_CONFIG, 3, {8'h0, 6'h0, i[1:0], 8'h0, 5'h0, i[2], 2'h0});
      chk({6'h0, gtab[i]}, {6'h0, gain});
    end
    wr(LPS_OFF_LTIME, 3, {8'h0, 8'hFF, 8'h00, 8'hED});
    wr(LPS_OFF_ENABLE, 1, 32'h0F);
    rd(LPS_OFF_ENABLE, 1, 32'h0F, 8'hFF);
    wait_for(0, 1'b1, n);
    wait_for(0, 1'b0, n);
    wait_for(1, 1'b1, gap);
    chk(16'h1, {15'h0, (gap >= S) && (gap <= S + 6)});
    wait_for(1, 1'b0, n);
    chk(16'h1, {15'h0, (n >= 19 * S) && (n <= 19 * S + 4)});
    wait_for(0, 1'b1, n);
    chk(16'h1, {15'h0, prox_act});
    wr(LPS_OFF_ENABLE, 1, 32'h01);
    repeat (25 * S) @(negedge clk);
    adc0 = $random(seed);
    adc1 = $random(seed);
    rd(LPS_OFF_C0L, 4, {c1, c0}, 8'hFF);
    wr(LPS_OFF_ENABLE, 1, 32'h11);
    pulse(1);
    chk(16'h0, {15'h0, int_b});
    wr(LPS_OFF_STATUS, 1, 32'h30);
    chk(16'h1, {15'h0, int_b});
    pulse(0);
    chk(16'h1, {15'h0, int_b});
    rd(LPS_OFF_STATUS, 1, 32'h20, 8'h30);
    wr(LPS_OFF_ENABLE, 1, 32'h45);
    wait_for(0, 1'b1, n);
    pulse(0);
    chk(16'h1, {15'h0, asleep});
    repeat (3 * S) @(negedge clk);
    chk(16'h1, {15'h0, asleep});
    wr(LPS_OFF_ENABLE, 1, 32'h05);
    wait_for(0, 1'b1, n);
    chk(16'h1, {15'h0, prox_act});
    repeat (4) @(negedge clk);
    report_and_stop();
  end
endmodule

`default_nettype wire
